// ===== logic/pwdt_params.svh
// Purpose: constants of the password watchdog timer
// Assumes: 200 MHz system clock, word-indexed register port
// Notes: offsets are register indices on the plain port
`ifndef PWDT_PARAMS_SVH
`define PWDT_PARAMS_SVH
`define PWDT_ADDR_CON0 2'h0
`define PWDT_ADDR_CON1 2'h1
`define PWDT_ADDR_STAT 2'h2
`define PWDT_TIMEOUT_LOAD 16'hFFFC
`define PWDT_COUNT_MAX 16'hFFFF
`define PWDT_COUNT_ZERO 16'h0000
`define PWDT_PREWARN_LOAD 16'hFFFC
`define PWDT_GUARD_NIBBLE 4'hF
`define PWDT_DIV_FAST 14'h00FF
`define PWDT_DIV_SLOW 14'h3FFF
`define PWDT_RELOAD_RST 16'h0000
`define PWDT_PASSWORD_RST 8'h00
`endif

// ===== logic/pwdt_pkg.sv
// Purpose: types of the password watchdog timer
// Assumes: constants come from pwdt_params.svh
// Notes: all state of the core is one packed struct
package pwdt_pkg;
  typedef enum logic [1:0] {
    PWDT_TIMEOUT,
    PWDT_NORMAL,
    PWDT_DISABLED,
    PWDT_PREWARN
  } pwdt_mode_type;

  typedef struct packed {
    logic [1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic supervisor;
  } pwdt_bus_type;

  typedef struct packed {
    pwdt_mode_type mode;
    logic [15:0] timer_count;
    logic [13:0] prescale;
    logic end_of_init_bit;
    logic primary_ctrl_lock_flag;
    logic [7:0] user_password_field;
    logic [15:0] reload_value_field;
    logic input_freq_request;
    logic disable_request;
    logic input_freq_active;
    logic overflow_error_flag;
    logic access_error_flag;
    logic watchdog_nmi_request;
    logic watchdog_reset_request;
    logic bus_error;
    logic [31:0] rdata;
  } pwdt_state_type;
endpackage : pwdt_pkg

// ===== logic/pwdt_core.sv
// Purpose: password protected watchdog timer with end-of-init protection line
// Assumes: synchronous reset; watchdog_reset_in marks a reset the watchdog caused
// Notes: the reset requester holds rst_in while the watchdog reset output stands
//
// Summary of operation
// - time-out mode after reset and valid password
// - slowest prescaler after reset until request applies
// - end-of-init set leaves time-out to normal/disable
// - time-out error raises nmi, enters prewarning
// - normal counts from reload; service reloads
// - normal error raises nmi, enters prewarning
// - service password moves normal into time-out
// - disable halts counter, protection stays active
// - disable: valid access time-out, invalid prewarning
// - prewarning counts fixed period then resets
// - prewarning ignores writes, no mode change
// - error flags survive watchdog reset only
// - secondary write needs supervisor, end-of-init clear
// - secondary bits apply at next end-of-init set
// - password then modify; relock after modify
// - second write is modify with guard checks
// - cleared end-of-init unlocks protected registers
// - status read-only; control registers always readable
// - primary holds end-of-init, lock, password, reload
// - password formed from registers plus guard bits
// - time-out entry loads FFFC, keeps disable request
// - wrap FFFF to 0000 sets overflow error
// - normal entry loads reload, clears flags
`include "pwdt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pwdt_core (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic watchdog_reset_in,
  input wire logic [1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic supervisor_in,
  output logic [31:0] rdata_out,
  output logic bus_error_out,
  output logic end_of_init_line_out,
  output logic watchdog_nmi_request_out,
  output logic watchdog_reset_request_out
);

  // ****************************************
  // password and guard decoding
  // ****************************************
  function automatic logic password_ok(input logic [31:0] w, input pwdt_pkg::pwdt_state_type s);
    password_ok = (w[0] == s.end_of_init_bit) && !w[1] && (w[2] == s.input_freq_request) &&
                  (w[3] == s.disable_request) && (w[7:4] == `PWDT_GUARD_NIBBLE) &&
                  (w[15:8] == s.user_password_field) && (w[31:16] == s.reload_value_field);
  endfunction : password_ok

  function automatic logic modify_ok(input logic [31:0] w);
    modify_ok = w[1] && !w[2] && !w[3] && (w[7:4] == `PWDT_GUARD_NIBBLE);
  endfunction : modify_ok

  pwdt_pkg::pwdt_bus_type bus;
  pwdt_pkg::pwdt_state_type state_q;
  pwdt_pkg::pwdt_state_type state_d;
  logic tick;
  logic wrap;
  logic con0_wr;
  logic con1_wr;
  logic valid_pw;
  logic valid_mod;
  logic bad_access;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in, supervisor: supervisor_in};
  assign tick = state_q.prescale == (state_q.input_freq_active ? `PWDT_DIV_FAST : `PWDT_DIV_SLOW);
  assign wrap = tick && (state_q.timer_count == `PWDT_COUNT_MAX);
  assign con0_wr = bus.wr && (bus.addr == `PWDT_ADDR_CON0) && (state_q.mode != pwdt_pkg::PWDT_PREWARN);
  assign con1_wr = bus.wr && (bus.addr == `PWDT_ADDR_CON1) && (state_q.mode != pwdt_pkg::PWDT_PREWARN);
  assign valid_pw = con0_wr && state_q.primary_ctrl_lock_flag && password_ok(bus.wdata, state_q);
  assign valid_mod = con0_wr && !state_q.primary_ctrl_lock_flag && modify_ok(bus.wdata);
  assign bad_access = con0_wr && !valid_pw && !valid_mod;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    state_d.bus_error = 1'b0;
    state_d.rdata = 32'h0000_0000;
    state_d.prescale = tick ? 14'h0000 : 14'(state_q.prescale + 14'h0001);
    // counting, stopped only in disable mode
    if (tick && state_q.mode != pwdt_pkg::PWDT_DISABLED) begin
      state_d.timer_count = 16'(state_q.timer_count + 16'h0001);
    end
    // secondary register writes
    if (con1_wr) begin
      if (bus.supervisor && !state_q.end_of_init_bit) begin
        state_d.input_freq_request = bus.wdata[0];
        state_d.disable_request = bus.wdata[1];
      end else begin
        state_d.bus_error = 1'b1;
      end
    end
    unique case (state_q.mode)
      pwdt_pkg::PWDT_PREWARN: begin
        if (wrap) begin
          state_d.watchdog_reset_request = 1'b1;
        end
      end
      default: begin
        if (bad_access || (wrap && state_q.mode != pwdt_pkg::PWDT_DISABLED)) begin
          state_d.mode = pwdt_pkg::PWDT_PREWARN;
          state_d.access_error_flag = state_q.access_error_flag | bad_access;
          state_d.overflow_error_flag = state_q.overflow_error_flag | (wrap && !bad_access);
          state_d.watchdog_nmi_request = 1'b1;
          state_d.timer_count = `PWDT_PREWARN_LOAD;
          state_d.primary_ctrl_lock_flag = 1'b1;
        end else if (valid_pw) begin
          state_d.primary_ctrl_lock_flag = 1'b0;
          if (state_q.mode != pwdt_pkg::PWDT_TIMEOUT) begin
            state_d.mode = pwdt_pkg::PWDT_TIMEOUT;
            state_d.timer_count = `PWDT_TIMEOUT_LOAD;
          end
        end else if (valid_mod) begin
          state_d.primary_ctrl_lock_flag = 1'b1;
          state_d.end_of_init_bit = bus.wdata[0];
          state_d.user_password_field = bus.wdata[15:8];
          state_d.reload_value_field = bus.wdata[31:16];
          if (bus.wdata[0] && state_q.mode == pwdt_pkg::PWDT_TIMEOUT) begin
            state_d.input_freq_active = state_q.input_freq_request;
            state_d.prescale = 14'h0000;
            if (state_q.disable_request) begin
              state_d.mode = pwdt_pkg::PWDT_DISABLED;
            end else begin
              state_d.mode = pwdt_pkg::PWDT_NORMAL;
              state_d.timer_count = bus.wdata[31:16];
              state_d.access_error_flag = 1'b0;
              state_d.overflow_error_flag = 1'b0;
            end
          end
        end
      end
    endcase
    // register reads
    if (bus.rd) begin
      unique case (bus.addr)
        `PWDT_ADDR_CON0: state_d.rdata = {state_q.reload_value_field, state_q.user_password_field, 4'h0,
                                          2'b00, state_q.primary_ctrl_lock_flag, state_q.end_of_init_bit};
        `PWDT_ADDR_CON1: state_d.rdata = {28'h000_0000, state_q.disable_request, state_q.input_freq_request,
                                          2'b00};
        `PWDT_ADDR_STAT: state_d.rdata = {state_q.timer_count, 9'h000, state_q.input_freq_active,
                                          state_q.mode == pwdt_pkg::PWDT_DISABLED,
                                          state_q.mode == pwdt_pkg::PWDT_PREWARN,
                                          state_q.mode == pwdt_pkg::PWDT_TIMEOUT,
                                          1'b0, state_q.overflow_error_flag, state_q.access_error_flag};
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q.mode <= pwdt_pkg::PWDT_TIMEOUT;
      state_q.timer_count <= `PWDT_TIMEOUT_LOAD;
      state_q.prescale <= 14'h0000;
      state_q.end_of_init_bit <= 1'b0;
      state_q.primary_ctrl_lock_flag <= 1'b1;
      state_q.user_password_field <= `PWDT_PASSWORD_RST;
      state_q.reload_value_field <= `PWDT_RELOAD_RST;
      state_q.input_freq_request <= 1'b0;
      state_q.disable_request <= 1'b0;
      state_q.input_freq_active <= 1'b0;
      // error flags kept only across a watchdog caused reset
      state_q.overflow_error_flag <= watchdog_reset_in & state_q.overflow_error_flag;
      state_q.access_error_flag <= watchdog_reset_in & state_q.access_error_flag;
      state_q.watchdog_nmi_request <= 1'b0;
      state_q.watchdog_reset_request <= 1'b0;
      state_q.bus_error <= 1'b0;
      state_q.rdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata_out = state_q.rdata;
  assign bus_error_out = state_q.bus_error;
  assign end_of_init_line_out = state_q.end_of_init_bit;
  assign watchdog_nmi_request_out = state_q.watchdog_nmi_request;
  assign watchdog_reset_request_out = state_q.watchdog_reset_request;

  // ****************************************
  // assertions
  // ****************************************
  sequence pw_seq;
    valid_pw;
  endsequence

  sequence mod_end_seq;
    valid_mod && bus.wdata[0] && state_q.mode == pwdt_pkg::PWDT_TIMEOUT;
  endsequence

  timeout_entry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    pw_seq |=> state_q.mode == pwdt_pkg::PWDT_TIMEOUT && !state_q.primary_ctrl_lock_flag)
    else $error("password did not enter time-out");
  end_init_exit_a: assert property (@(posedge clock_in) disable iff (rst_in)
    mod_end_seq |=> state_q.mode == ($past(state_q.disable_request) ? pwdt_pkg::PWDT_DISABLED : pwdt_pkg::PWDT_NORMAL))
    else $error("end-of-init set gave wrong mode");
  error_prewarn_a: assert property (@(posedge clock_in) disable iff (rst_in)
    bad_access |=> state_q.mode == pwdt_pkg::PWDT_PREWARN && state_q.access_error_flag && state_q.watchdog_nmi_request)
    else $error("bad access did not prewarn");
  normal_load_a: assert property (@(posedge clock_in) disable iff (rst_in)
    mod_end_seq and !state_q.disable_request |=> state_q.timer_count == $past(bus.wdata[31:16]))
    else $error("normal entry reload wrong");
  disable_halt_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q.mode == pwdt_pkg::PWDT_DISABLED ##1 state_q.mode == pwdt_pkg::PWDT_DISABLED
    |-> $stable(state_q.timer_count))
    else $error("counter moved in disable mode");
  prewarn_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q.mode == pwdt_pkg::PWDT_PREWARN |=> state_q.mode == pwdt_pkg::PWDT_PREWARN)
    else $error("prewarning left");
  prewarn_reset_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q.mode == pwdt_pkg::PWDT_PREWARN && wrap |=> watchdog_reset_request_out)
    else $error("no reset after prewarning period");
  con1_guard_a: assert property (@(posedge clock_in) disable iff (rst_in)
    con1_wr && state_q.end_of_init_bit |=> bus_error_out && $stable(state_q.disable_request))
    else $error("protected write not refused");
  nmi_sticky_a: assert property (@(posedge clock_in) disable iff (rst_in)
    watchdog_nmi_request_out |=> watchdog_nmi_request_out)
    else $error("nmi dropped");
  relock_a: assert property (@(posedge clock_in) disable iff (rst_in)
    valid_mod |=> state_q.primary_ctrl_lock_flag)
    else $error("modify did not relock");

  // ****************************************
  // mode transition checks
  // ****************************************
  sequence svc_pw_seq;
    valid_pw && state_q.mode == pwdt_pkg::PWDT_NORMAL;
  endsequence

  sequence dis_pw_seq;
    valid_pw && state_q.mode == pwdt_pkg::PWDT_DISABLED;
  endsequence

  sequence run_wrap_seq;
    wrap && !bad_access && (state_q.mode == pwdt_pkg::PWDT_TIMEOUT || state_q.mode == pwdt_pkg::PWDT_NORMAL);
  endsequence

  sequence bad_pw_seq;
    con0_wr && state_q.primary_ctrl_lock_flag && !valid_pw;
  endsequence

  service_timeout_a: assert property (@(posedge clock_in) disable iff (rst_in)
    svc_pw_seq |=> state_q.mode == pwdt_pkg::PWDT_TIMEOUT && state_q.timer_count == `PWDT_TIMEOUT_LOAD &&
    $stable(state_q.end_of_init_bit))
    else $error("service password did not enter time-out");

  disable_valid_a: assert property (@(posedge clock_in) disable iff (rst_in)
    dis_pw_seq |=> state_q.mode == pwdt_pkg::PWDT_TIMEOUT)
    else $error("valid access in disable mode did not enter time-out");

  overflow_prewarn_a: assert property (@(posedge clock_in) disable iff (rst_in)
    run_wrap_seq |=> state_q.mode == pwdt_pkg::PWDT_PREWARN && state_q.overflow_error_flag &&
    watchdog_nmi_request_out)
    else $error("overflow did not prewarn");

  bad_password_a: assert property (@(posedge clock_in) disable iff (rst_in)
    bad_pw_seq |=> state_q.mode == pwdt_pkg::PWDT_PREWARN && state_q.access_error_flag)
    else $error("wrong password not flagged");

  prewarn_load_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(state_q.mode == pwdt_pkg::PWDT_PREWARN) |-> state_q.timer_count == `PWDT_PREWARN_LOAD)
    else $error("prewarning period not loaded");

  reset_entry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $fell(rst_in) |-> state_q.mode == pwdt_pkg::PWDT_TIMEOUT && state_q.timer_count == `PWDT_TIMEOUT_LOAD &&
    !state_q.end_of_init_bit && state_q.primary_ctrl_lock_flag && !state_q.input_freq_active)
    else $error("reset state wrong");

  normal_count_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q.mode == pwdt_pkg::PWDT_NORMAL && tick && !con0_wr && !wrap
    |=> state_q.timer_count == 16'($past(state_q.timer_count) + 16'h0001))
    else $error("normal mode did not count up");

  normal_flags_a: assert property (@(posedge clock_in) disable iff (rst_in)
    mod_end_seq and !state_q.disable_request |=> !state_q.access_error_flag && !state_q.overflow_error_flag)
    else $error("normal entry kept error flags");

  modify_fields_a: assert property (@(posedge clock_in) disable iff (rst_in)
    valid_mod |=> state_q.reload_value_field == $past(bus.wdata[31:16]) &&
    state_q.user_password_field == $past(bus.wdata[15:8]) && state_q.end_of_init_bit == $past(bus.wdata[0]))
    else $error("modify fields not taken");

  // ****************************************
  // register and output checks
  // ****************************************
  prewarn_ignore_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q.mode == pwdt_pkg::PWDT_PREWARN && bus.wr |=> $stable(state_q.reload_value_field) &&
    $stable(state_q.user_password_field) && $stable(state_q.end_of_init_bit) &&
    $stable(state_q.disable_request) && $stable(state_q.input_freq_request))
    else $error("write took effect in prewarning");

  sup_guard_a: assert property (@(posedge clock_in) disable iff (rst_in)
    con1_wr && !bus.supervisor |=> bus_error_out && $stable(state_q.input_freq_request))
    else $error("user mode write not refused");

  berr_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !con1_wr |=> !bus_error_out)
    else $error("bus error without secondary write");

  con1_accept_a: assert property (@(posedge clock_in) disable iff (rst_in)
    con1_wr && bus.supervisor && !state_q.end_of_init_bit
    |=> !bus_error_out && state_q.disable_request == $past(bus.wdata[1]))
    else $error("unlocked secondary write refused");

  request_only_a: assert property (@(posedge clock_in) disable iff (rst_in)
    con1_wr |=> $stable(state_q.input_freq_active))
    else $error("frequency request applied at once");

  status_ro_a: assert property (@(posedge clock_in) disable iff (rst_in)
    bus.wr && bus.addr == `PWDT_ADDR_STAT |=> $stable(state_q.reload_value_field) &&
    $stable(state_q.input_freq_request) && $stable(state_q.disable_request))
    else $error("status write changed a register");

  read_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !bus.rd |=> rdata_out == 32'h0000_0000)
    else $error("read data outside read cycle");

  con0_guard_read_a: assert property (@(posedge clock_in) disable iff (rst_in)
    bus.rd && bus.addr == `PWDT_ADDR_CON0 |=> rdata_out[7:4] == 4'h0)
    else $error("guard bits not read as zero");

  status_onehot_a: assert property (@(posedge clock_in) disable iff (rst_in)
    bus.rd && bus.addr == `PWDT_ADDR_STAT |=> $countones(rdata_out[5:3]) <= 1)
    else $error("more than one mode indicator");

  nmi_entry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(watchdog_nmi_request_out) |-> state_q.mode == pwdt_pkg::PWDT_PREWARN)
    else $error("nmi outside prewarning");

  reset_prewarn_a: assert property (@(posedge clock_in) disable iff (rst_in)
    watchdog_reset_request_out |-> state_q.mode == pwdt_pkg::PWDT_PREWARN)
    else $error("reset request outside prewarning");

  flags_clear_a: assert property (@(posedge clock_in)
    rst_in && !watchdog_reset_in |=> !state_q.overflow_error_flag && !state_q.access_error_flag)
    else $error("software reset kept error flags");

  flags_keep_a: assert property (@(posedge clock_in)
    rst_in && watchdog_reset_in |=> $stable(state_q.overflow_error_flag) && $stable(state_q.access_error_flag))
    else $error("watchdog reset lost error flags");

endmodule : pwdt_core
`default_nettype wire

// ===== dv/pwdt_reset_model.sv
// Purpose: system reset logic that answers the watchdog reset request
// Assumes: one clock; software reset comes from the bench
// Notes: a watchdog reset is held three cycles and flagged as such
`timescale 1ns/1ps
`default_nettype none
module pwdt_reset_model (
  input wire logic clock_in,
  input wire logic sw_rst_in,
  input wire logic reset_req_in,
  output logic rst_out,
  output logic wdg_rst_out
);
  logic [1:0] hold_q;
  // ****************
  // reset stretcher
  // ****************
  always_ff @(posedge clock_in) begin
    if (sw_rst_in) begin
      hold_q <= 2'h0;
    end else if (reset_req_in && hold_q == 2'h0) begin
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  assign rst_out = sw_rst_in || hold_q != 2'h0;
  assign wdg_rst_out = hold_q != 2'h0;
endmodule : pwdt_reset_model
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench of the password watchdog
// Assumes: fast prescaler chosen so that overflows come quickly
// Notes: random password field and reload value
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in, sw_rst, rst_in, wdg_rst, wr, rd, sup, berr, eoi_line, nmi, rst_req;
  logic [1:0] addr;
  logic [31:0] wdata, rdata, r;
  logic [7:0] pw;
  logic [15:0] rel;
  int mismatches, n_compared;
  pwdt_core i_pwdt_core (.clock_in(clock_in), .rst_in(rst_in), .watchdog_reset_in(wdg_rst),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .supervisor_in(sup),
    .rdata_out(rdata), .bus_error_out(berr), .end_of_init_line_out(eoi_line),
    .watchdog_nmi_request_out(nmi), .watchdog_reset_request_out(rst_req));
  pwdt_reset_model i_pwdt_reset_model (.clock_in(clock_in), .sw_rst_in(sw_rst),
    .reset_req_in(rst_req), .rst_out(rst_in), .wdg_rst_out(wdg_rst));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] pw_of(input logic [15:0] rl, input logic [7:0] p, input logic dr, input logic ir,
                                        input logic e);
    return {rl, p, 4'hf, dr, ir, 1'b0, e};
  endfunction : pw_of
  function automatic logic [31:0] mod_of(input logic [15:0] rl, input logic [7:0] p, input logic e);
    return {rl, p, 4'hf, 2'b00, 1'b1, e};
  endfunction : mod_of
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus_wr(input logic [1:0] a, input logic [31:0] d, input logic s);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    sup <= s;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  task automatic wait_on(input bit rq, input int lim);
    int i;
    for (i = 0; i < lim && !(rq ? rst_req === 1'b1 : nmi === 1'b1); i++) @(posedge clock_in);
    #1;
  endtask : wait_on
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    report_and_stop();
  end
  // ****************
  // tests
  // ****************
  initial begin
    sw_rst = 1'b1; wr = 1'b0; rd = 1'b0; sup = 1'b0; addr = 2'h0; wdata = 32'h0000_0000;
    mismatches = 0; n_compared = 0;
    void'($urandom(32'h35bf_7ee1));
    pw = 8'($urandom);
    rel = 16'($urandom);
    repeat (3) @(posedge clock_in);
    sw_rst <= 1'b0;
    bus_rd(2'h2, r); chk("status", 32'hfffc_0008, r);
    bus_rd(2'h0, r); chk("primary", 32'h0000_0002, r);
    chk("eoi line", 32'h0, eoi_line);
    bus_rd(2'h3, r); chk("unmapped", 32'h0, r);
    bus_wr(2'h1, 32'h0000_0003, 1'b0); chk("berr user", 32'h1, berr);
    bus_wr(2'h1, 32'h0000_0001, 1'b1); chk("berr sup", 32'h0, berr);
    bus_rd(2'h1, r); chk("secondary", 32'h0000_0004, r);
    bus_wr(2'h2, $urandom, 1'b1); bus_rd(2'h2, r); chk("status ro", 32'hfffc_0008, r);
    $display("test reset and protection done");
    bus_wr(2'h0, pw_of(16'h0, 8'h0, 1'b0, 1'b1, 1'b0), 1'b1);
    bus_rd(2'h0, r); chk("unlocked", 32'h0, r);
    bus_wr(2'h0, mod_of(rel, pw, 1'b1), 1'b1);
    bus_rd(2'h0, r); chk("relocked", {rel, pw, 8'h03}, r);
    bus_rd(2'h2, r); chk("normal", 32'h0040, r[15:0]);
    chk("eoi line", 32'h1, eoi_line);
    bus_wr(2'h1, 32'h0, 1'b1); chk("berr eoi", 32'h1, berr);
    bus_wr(2'h0, pw_of(rel, pw, 1'b0, 1'b1, 1'b1), 1'b1);
    bus_rd(2'h2, r); chk("service", 32'h0048, r[15:0]);
    bus_wr(2'h0, mod_of(16'hfffe, pw, 1'b1), 1'b1);
    $display("test service done");
    wait_on(1'b0, 700); chk("nmi overflow", 32'h1, nmi);
    bus_rd(2'h2, r); chk("prewarn", 32'h0052, r[15:0]);
    bus_wr(2'h0, pw_of(16'hfffe, pw, 1'b0, 1'b1, 1'b1), 1'b1);
    bus_rd(2'h0, r); chk("ignored", {16'hfffe, pw, 8'h03}, r);
    chk("nmi held", 32'h1, nmi);
    wait_on(1'b1, 1500); chk("reset req", 32'h1, rst_req);
    repeat (5) @(posedge clock_in);
    bus_rd(2'h2, r); chk("after wdg reset", 32'hfffc_000a, r);
    chk("nmi cleared", 32'h0, nmi);
    $display("test overflow and prewarning done");
    bus_wr(2'h0, 32'h0000_0000, 1'b1);
    wait_on(1'b0, 4); chk("nmi access", 32'h1, nmi);
    bus_rd(2'h2, r); chk("access err", 32'h0013, r[15:0]);
    @(posedge clock_in);
    sw_rst <= 1'b1;
    repeat (3) @(posedge clock_in);
    sw_rst <= 1'b0;
    bus_rd(2'h2, r); chk("after sw reset", 32'hfffc_0008, r);
    $display("test access error done");
    bus_wr(2'h1, 32'h0000_0003, 1'b1); chk("berr dis req", 32'h0, berr);
    bus_wr(2'h0, pw_of(16'h0, 8'h0, 1'b1, 1'b1, 1'b0), 1'b1);
    bus_wr(2'h0, mod_of(16'h0, 8'h0, 1'b1), 1'b1);
    repeat (600) @(posedge clock_in);
    bus_rd(2'h2, r); chk("disabled", 32'hfffc_0060, r);
    bus_wr(2'h0, pw_of(16'h0, 8'h0, 1'b1, 1'b1, 1'b1), 1'b1);
    bus_rd(2'h2, r); chk("disable exit", 32'hfffc_0048, r);
    $display("test disable done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
